//--- src/nibble_io_pkg.sv
// constants shared by the nibble i/o port block
// assumes a 4-bit core data bus with 7-bit data memory addresses
package nibble_io_pkg;

	localparam int unsigned NIBBLE_W  = 4;   // data memory word width
	localparam int unsigned ADDR_W    = 7;   // data memory address width
	localparam int unsigned OD_PINS   = 3;   // open-drain pins implemented
	localparam int unsigned PP_PINS   = 4;   // push-pull pins per port

	// port register offsets in data memory
	localparam logic [6:0] OPEN_DRAIN_LATCH_ADDR   = 7'h71;
	localparam logic [6:0] PUSH_PULL_ONE_LATCH_ADDR = 7'h72;
	localparam logic [6:0] PUSH_PULL_TWO_LATCH_ADDR = 7'h73;

	// field positions
	localparam int unsigned PHANTOM_BIT   = 3;  // open-drain bit 3, absent
	localparam int unsigned HALT_WAKE_BIT = 0;  // open-drain pin 0
	localparam int unsigned STOP_WAKE_BIT = 1;  // open-drain pin 1

	// values after reset
	localparam logic [3:0] LATCH_RESET   = 4'hF;  // all ones, no pull-down
	localparam logic [3:0] READ_RESET    = 4'h0;  // read data register
	localparam logic       MODE_RESET    = 1'h0;  // input mode
	localparam logic [2:0] SELECT_NONE   = 3'h0;  // no port addressed

	// input filter depth in flip-flops
	localparam int unsigned SYNC_STAGES = 3;

endpackage : nibble_io_pkg

//--- src/port_ctrl_if.sv
// control and status bundle between the top and one port slice
// assumes both ends sit on the same clock
interface port_ctrl_if;

	logic       wrStrobe;  // one-cycle write of the port register
	logic [3:0] wrData;    // nibble to store
	logic [3:0] pinLevel;  // filtered pin levels, unused bits zero
	logic       outMode;   // port has left input mode

	// top side drives writes and reads the status back
	modport host (
		output wrStrobe,
		output wrData,
		input  pinLevel,
		input  outMode
	);

	// port slice side
	modport port (
		input  wrStrobe,
		input  wrData,
		output pinLevel,
		output outMode
	);

endinterface : port_ctrl_if

//--- src/nibble_port.sv
// one nibble port: latch, sticky direction, pin drivers, input filter
// assumes pin inputs are asynchronous to clk and writes come as strobes
module nibble_port #(
	parameter int unsigned WIDTH      = 4,  // implemented pins
	parameter bit          OPEN_DRAIN = 0   // 1: drivers only pull low
) (
	input  wire logic             clk,
	input  wire logic             rst,
	port_ctrl_if.port             ctl,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinOut,
	output logic      [WIDTH-1:0] pinOe
);

	logic [WIDTH-1:0] latch_reg, latch_next;  // port register
	logic             mode_reg, mode_next;    // 1 once in output mode
	logic [WIDTH-1:0] out_reg, out_next;      // pin output value
	logic [WIDTH-1:0] oe_reg, oe_next;        // pin output enable
	logic [WIDTH-1:0] sync1_reg;              // first stage, to sync2 only
	logic [WIDTH-1:0] sync2_reg;              // second stage
	logic [WIDTH-1:0] sync3_reg;              // third stage
	logic [WIDTH-1:0] level_reg, level_next;  // accepted pin level

	// next latch, direction and drive
	always_comb begin
		latch_next = latch_reg;
		mode_next  = mode_reg;  // never cleared but by reset
		if (ctl.wrStrobe) begin
			// upper bits beyond WIDTH are dropped
			latch_next = ctl.wrData[WIDTH-1:0];
			mode_next  = 1'b1;  // whole nibble to output
		end
		if (OPEN_DRAIN) begin
			// one floats, zero pulls low
			out_next = '0;
			oe_next  = {WIDTH{mode_next}} & ~latch_next;
		end else begin
			// push-pull drives the held latch
			out_next = latch_next;
			oe_next  = {WIDTH{mode_next}};
		end
	end

	// accept a bit only when stages two and three agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			if (sync2_reg[i] == sync3_reg[i]) begin
				level_next[i] = sync3_reg[i];
			end else begin
				level_next[i] = level_reg[i];
			end
		end
	end

	// register everything; drive changes on the write edge
	always_ff @(posedge clk) begin
		if (rst) begin
			latch_reg <= nibble_io_pkg::LATCH_RESET[WIDTH-1:0];
			mode_reg  <= nibble_io_pkg::MODE_RESET;  // inputs
			out_reg   <= '0;
			oe_reg    <= '0;
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			level_reg <= '0;
		end else begin
			latch_reg <= latch_next;
			mode_reg  <= mode_next;
			out_reg   <= out_next;
			oe_reg    <= oe_next;
			sync1_reg <= pinIn;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			level_reg <= level_next;
		end
	end

	// status back to the top, missing bits read zero
	always_comb begin
		ctl.pinLevel              = '0;
		ctl.pinLevel[WIDTH-1:0]   = level_reg;
		ctl.outMode               = mode_reg;
	end

	assign pinOut = out_reg;
	assign pinOe  = oe_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// latch moves only on a write
	chk_latch_only_write: assert property (
		!ctl.wrStrobe |=> $stable(latch_reg))
		else $error("port latch changed without a write");

	// filtered level follows a settled pin within four cycles
	chk_filter_follows: assert property (
		$stable(pinIn) [*4] |=> level_reg == $past(pinIn, 2))
		else $error("filtered level did not follow a steady pin");

endmodule : nibble_port

//--- src/nibble_io_ports.sv
// three nibble i/o ports on the core data memory bus
// assumes one core write or read per cycle, pins asynchronous to clk
//
// Contract
// - open-drain port of three pins
// - two push-pull four-pin ports, same behaviour
// - direction per whole port, inputs after reset
// - write 71H loads, open-drain port outputs
// - write 72H loads, first push-pull outputs
// - write 73H loads, second push-pull outputs
// - output mode holds until next reset
// - pins keep driving last written value
// - open-drain one floats, pin readable
// - reads return pin levels, latch untouched
// - open-drain bit 3 absent, reads zero
// - high on pin 0 releases halt
// - high on pin 1 releases stop
// - read-modify-write sees pin levels
module nibble_io_ports (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [6:0] memAddr,
	input  wire logic       memWrEn,
	input  wire logic [3:0] memWrData,
	input  wire logic       memRdEn,
	output logic      [3:0] memRdData,
	input  wire logic       haltWakePinIn,
	output logic            haltWakePinOut,
	output logic            haltWakePinOe,
	input  wire logic       stopWakePinIn,
	output logic            stopWakePinOut,
	output logic            stopWakePinOe,
	input  wire logic       openDrainPinTwoIn,
	output logic            openDrainPinTwoOut,
	output logic            openDrainPinTwoOe,
	input  wire logic [3:0] pushPullGroupOnePinsIn,
	output logic      [3:0] pushPullGroupOnePinsOut,
	output logic      [3:0] pushPullGroupOnePinsOe,
	input  wire logic [3:0] pushPullGroupTwoPinsIn,
	output logic      [3:0] pushPullGroupTwoPinsOut,
	output logic      [3:0] pushPullGroupTwoPinsOe,
	output logic            haltRelease,
	output logic            stopRelease
);

	// one-hot port select: bit 0 open-drain, 1 and 2 push-pull
	function automatic logic [2:0] portSelect(input logic [6:0] addr);
		logic [2:0] sel;
		sel = nibble_io_pkg::SELECT_NONE;
		unique case (addr)
			nibble_io_pkg::OPEN_DRAIN_LATCH_ADDR:    sel = 3'h1;
			nibble_io_pkg::PUSH_PULL_ONE_LATCH_ADDR: sel = 3'h2;
			nibble_io_pkg::PUSH_PULL_TWO_LATCH_ADDR: sel = 3'h4;
			default:                                 sel = 3'h0;
		endcase
		return sel;
	endfunction : portSelect

	port_ctrl_if odCtl ();   // open-drain port
	port_ctrl_if ppOne ();   // first push-pull port
	port_ctrl_if ppTwo ();   // second push-pull port

	logic [2:0] wrSel;                       // write target
	logic [2:0] rdSel;                       // read target
	logic [3:0] rdData_reg, rdData_next;     // read data register
	logic       halt_reg, halt_next;         // halt release level
	logic       stop_reg, stop_next;         // stop release level
	logic [2:0] odOut;                       // open-drain drive value
	logic [2:0] odOe;                        // open-drain enables
	logic [2:0] odIn;                        // open-drain pin inputs

	// address decode for both directions
	always_comb begin
		wrSel = memWrEn ? portSelect(memAddr) : nibble_io_pkg::SELECT_NONE;
		rdSel = memRdEn ? portSelect(memAddr) : nibble_io_pkg::SELECT_NONE;
	end

	// write strobes into the three port slices
	always_comb begin
		odCtl.wrStrobe = wrSel[0];
		odCtl.wrData   = memWrData;
		ppOne.wrStrobe = wrSel[1];
		ppOne.wrData   = memWrData;
		ppTwo.wrStrobe = wrSel[2];
		ppTwo.wrData   = memWrData;
	end

	assign odIn = {openDrainPinTwoIn, stopWakePinIn, haltWakePinIn};

	// open-drain port, three pins, low or float
	nibble_port #(
		.WIDTH      (nibble_io_pkg::OD_PINS),
		.OPEN_DRAIN (1'b1)
	) odPort (
		.clk    (clk),
		.rst    (rst),
		.ctl    (odCtl),
		.pinIn  (odIn),
		.pinOut (odOut),
		.pinOe  (odOe)
	);

	// first push-pull port
	nibble_port #(
		.WIDTH      (nibble_io_pkg::PP_PINS),
		.OPEN_DRAIN (1'b0)
	) ppOnePort (
		.clk    (clk),
		.rst    (rst),
		.ctl    (ppOne),
		.pinIn  (pushPullGroupOnePinsIn),
		.pinOut (pushPullGroupOnePinsOut),
		.pinOe  (pushPullGroupOnePinsOe)
	);

	// second push-pull port
	nibble_port #(
		.WIDTH      (nibble_io_pkg::PP_PINS),
		.OPEN_DRAIN (1'b0)
	) ppTwoPort (
		.clk    (clk),
		.rst    (rst),
		.ctl    (ppTwo),
		.pinIn  (pushPullGroupTwoPinsIn),
		.pinOut (pushPullGroupTwoPinsOut),
		.pinOe  (pushPullGroupTwoPinsOe)
	);

	// split open-drain drivers onto the named pins
	assign haltWakePinOut     = odOut[nibble_io_pkg::HALT_WAKE_BIT];
	assign haltWakePinOe      = odOe[nibble_io_pkg::HALT_WAKE_BIT];
	assign stopWakePinOut     = odOut[nibble_io_pkg::STOP_WAKE_BIT];
	assign stopWakePinOe      = odOe[nibble_io_pkg::STOP_WAKE_BIT];
	assign openDrainPinTwoOut = odOut[2];
	assign openDrainPinTwoOe  = odOe[2];

	// read mux: pin levels, never the latch
	always_comb begin
		rdData_next = rdData_reg;  // hold between reads
		if (memRdEn) begin
			unique case (rdSel)
				3'h1:    rdData_next = odCtl.pinLevel;  // bit 3 zero
				3'h2:    rdData_next = ppOne.pinLevel;
				3'h4:    rdData_next = ppTwo.pinLevel;
				default: rdData_next = nibble_io_pkg::READ_RESET;
			endcase
		end
	end

	// wake levels from filtered open-drain pins 0 and 1
	always_comb begin
		halt_next = odCtl.pinLevel[nibble_io_pkg::HALT_WAKE_BIT];
		stop_next = odCtl.pinLevel[nibble_io_pkg::STOP_WAKE_BIT];
	end

	// register read data and wake levels
	always_ff @(posedge clk) begin
		if (rst) begin
			rdData_reg <= nibble_io_pkg::READ_RESET;
			halt_reg   <= 1'b0;
			stop_reg   <= 1'b0;
		end else begin
			rdData_reg <= rdData_next;
			halt_reg   <= halt_next;
			stop_reg   <= stop_next;
		end
	end

	assign memRdData   = rdData_reg;
	assign haltRelease = halt_reg;
	assign stopRelease = stop_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// write cycles per port
	sequence odWrite;
		memWrEn && memAddr == nibble_io_pkg::OPEN_DRAIN_LATCH_ADDR;
	endsequence

	sequence ppOneWrite;
		memWrEn && memAddr == nibble_io_pkg::PUSH_PULL_ONE_LATCH_ADDR;
	endsequence

	sequence ppTwoWrite;
		memWrEn && memAddr == nibble_io_pkg::PUSH_PULL_TWO_LATCH_ADDR;
	endsequence

	// read cycles for the open-drain and first push-pull ports
	sequence odRead;
		memRdEn && memAddr == nibble_io_pkg::OPEN_DRAIN_LATCH_ADDR;
	endsequence

	sequence ppOneRead;
		memRdEn && memAddr == nibble_io_pkg::PUSH_PULL_ONE_LATCH_ADDR;
	endsequence

	// a write puts the port in output mode by the next edge
	chk_od_write_mode: assert property (
		odWrite |=> odCtl.outMode)
		else $error("open-drain write did not enter output mode");

	// push-pull write drives data on all four pins next cycle
	chk_pp_one_drive: assert property (
		ppOneWrite |=> pushPullGroupOnePinsOe == 4'hF
			&& pushPullGroupOnePinsOut == $past(memWrData))
		else $error("first push-pull write not driven next cycle");

	chk_pp_two_drive: assert property (
		ppTwoWrite |=> pushPullGroupTwoPinsOe == 4'hF
			&& pushPullGroupTwoPinsOut == $past(memWrData))
		else $error("second push-pull write not driven next cycle");

	// output mode never drops back once all three ports are in it
	chk_mode_sticky: assert property (
		(odCtl.outMode && ppOne.outMode && ppTwo.outMode)
			|=> odCtl.outMode && ppOne.outMode && ppTwo.outMode)
		else $error("a port left output mode without reset");

	// all pins undriven right after reset
	chk_reset_inputs: assert property (
		$fell(rst) |-> odOe == 3'h0 && pushPullGroupOnePinsOe == 4'h0
			&& pushPullGroupTwoPinsOe == 4'h0)
		else $error("a pin is driven straight after reset");

	// drive holds while no write reaches the port
	chk_pp_hold: assert property (
		(ppOne.outMode && !(memWrEn
			&& memAddr == nibble_io_pkg::PUSH_PULL_ONE_LATCH_ADDR)) [*2]
			|=> $stable(pushPullGroupOnePinsOut))
		else $error("push-pull drive changed without a write");

	// open-drain one floats, zero pulls low, only in output mode
	chk_od_float: assert property (
		odWrite |=> odOut == 3'h0 && odOe == ~$past(memWrData[2:0]))
		else $error("open-drain enables do not match written zeros");

	// read returns filtered pin levels, one cycle later
	chk_read_pins: assert property (
		memRdEn && memAddr == nibble_io_pkg::PUSH_PULL_TWO_LATCH_ADDR
			|=> memRdData == $past(ppTwo.pinLevel))
		else $error("push-pull read did not return pin levels");

	// phantom bit reads zero
	chk_phantom_zero: assert property (
		memRdEn && memAddr == nibble_io_pkg::OPEN_DRAIN_LATCH_ADDR
			|=> memRdData[nibble_io_pkg::PHANTOM_BIT] == 1'b0)
		else $error("open-drain bit 3 read as one");

	// wake outputs track filtered pin 0 and pin 1
	chk_halt_wake: assert property (
		odCtl.pinLevel[0] |=> haltRelease)
		else $error("high pin 0 did not release halt");

	chk_stop_wake: assert property (
		odCtl.pinLevel[1] |=> stopRelease)
		else $error("high pin 1 did not release stop");

	// low pins leave the wake levels low
	chk_halt_low: assert property (
		!odCtl.pinLevel[0] |=> !haltRelease)
		else $error("low pin 0 still released halt");

	chk_stop_low: assert property (
		!odCtl.pinLevel[1] |=> !stopRelease)
		else $error("low pin 1 still released stop");

	// open-drain and first push-pull reads return filtered pins, never the latch
	chk_od_read_pins: assert property (
		odRead |=> memRdData == $past(odCtl.pinLevel))
		else $error("open-drain read did not return pin levels");

	chk_pp_one_read: assert property (
		ppOneRead |=> memRdData == $past(ppOne.pinLevel))
		else $error("first push-pull read did not return pin levels");

	// a read outside the three ports returns zero
	chk_read_unmapped: assert property (
		memRdEn && memAddr != nibble_io_pkg::OPEN_DRAIN_LATCH_ADDR
			&& memAddr != nibble_io_pkg::PUSH_PULL_ONE_LATCH_ADDR
			&& memAddr != nibble_io_pkg::PUSH_PULL_TWO_LATCH_ADDR
			|=> memRdData == nibble_io_pkg::READ_RESET)
		else $error("unmapped read returned nonzero data");

	// read data stands until the next read
	chk_read_hold: assert property (
		!memRdEn |=> $stable(memRdData))
		else $error("read data changed without a read");

	// each port on its own keeps output mode
	chk_od_sticky: assert property (
		odCtl.outMode |=> odCtl.outMode)
		else $error("open-drain port left output mode");

	chk_pp_one_sticky: assert property (
		ppOne.outMode |=> ppOne.outMode)
		else $error("first push-pull port left output mode");

	chk_pp_two_sticky: assert property (
		ppTwo.outMode |=> ppTwo.outMode)
		else $error("second push-pull port left output mode");

	// second push-pull drive holds without a write
	chk_pp_two_hold: assert property (
		ppTwo.outMode
			&& !(memWrEn
			&& memAddr == nibble_io_pkg::PUSH_PULL_TWO_LATCH_ADDR)
			|=> $stable(pushPullGroupTwoPinsOut))
		else $error("second push-pull drive changed without a write");

	// open-drain drive holds without a write
	chk_od_hold: assert property (
		odCtl.outMode
			&& !(memWrEn
			&& memAddr == nibble_io_pkg::OPEN_DRAIN_LATCH_ADDR)
			|=> $stable(odOe) && $stable(odOut))
		else $error("open-drain drive changed without a write");

	// a write outside the three ports touches no pin
	chk_write_unmapped: assert property (
		memWrEn && memAddr != nibble_io_pkg::OPEN_DRAIN_LATCH_ADDR
			&& memAddr != nibble_io_pkg::PUSH_PULL_ONE_LATCH_ADDR
			&& memAddr != nibble_io_pkg::PUSH_PULL_TWO_LATCH_ADDR
			|=> $stable(odOe) && $stable(pushPullGroupOnePinsOe)
			&& $stable(pushPullGroupTwoPinsOe))
		else $error("unmapped write changed a pin drive");

endmodule : nibble_io_ports

//--- testbench/pin_partner.sv
// external circuits on the port pins: pull-ups and drivers
// assumes enables from the ports are registered on the bench clock
module pin_partner (
	input  wire logic [2:0] odOe,      // open-drain pull-low enables
	input  wire logic [2:0] odOut,     // open-drain drive values
	input  wire logic [2:0] extLow,    // outside circuit pulls pin low
	input  wire logic [3:0] oneOe,     // first push-pull enables
	input  wire logic [3:0] oneOut,    // first push-pull values
	input  wire logic [3:0] oneExt,    // outside drive when released
	input  wire logic [3:0] twoOe,     // second push-pull enables
	input  wire logic [3:0] twoOut,    // second push-pull values
	input  wire logic [3:0] twoExt,    // outside drive when released
	output logic      [2:0] odLevel,   // resolved open-drain levels
	output logic      [3:0] oneLevel,  // resolved first port levels
	output logic      [3:0] twoLevel   // resolved second port levels
);
	// pull-up wins unless anyone pulls low
	assign odLevel = ~((odOe & ~odOut) | extLow);
	// chip driver wins where enabled, outside drive elsewhere
	assign oneLevel = (oneOe & oneOut) | (~oneOe & oneExt);
	assign twoLevel = (twoOe & twoOut) | (~twoOe & twoExt);
endmodule : pin_partner

//--- testbench/tb_top.sv
// self-checking bench for the three nibble ports
// assumes the partner model resolves every pin level
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk;        // system clock
	logic       rst;        // synchronous reset
	logic [6:0] memAddr;    // bus address
	logic       memWrEn;    // write strobe
	logic [3:0] memWrData;  // write nibble
	logic       memRdEn;    // read strobe
	logic [3:0] memRdData;  // read nibble
	logic [2:0] odIn;       // open-drain pin levels
	logic [2:0] odOut;      // open-drain drive values
	logic [2:0] odOe;       // open-drain pull-low enables
	logic [2:0] extLow;     // outside pull-low per pin
	logic [3:0] oneIn;      // first push-pull levels
	logic [3:0] oneOut;     // first push-pull values
	logic [3:0] oneOe;      // first push-pull enables
	logic [3:0] oneExt;     // outside drive, first port
	logic [3:0] twoIn;      // second push-pull levels
	logic [3:0] twoOut;     // second push-pull values
	logic [3:0] twoOe;      // second push-pull enables
	logic [3:0] twoExt;     // outside drive, second port
	logic       haltRel;    // halt release level
	logic       stopRel;    // stop release level
	logic       rdSeen;     // read answered this cycle
	logic [3:0] d;          // random nibble
	logic [3:0] expQ[$];    // expected read data
	int         n_errors;
	int         total_checks;

	nibble_io_ports nibble_io_ports_inst (
		.clk(clk), .rst(rst), .memAddr(memAddr), .memWrEn(memWrEn),
		.memWrData(memWrData), .memRdEn(memRdEn), .memRdData(memRdData),
		.haltWakePinIn(odIn[0]), .haltWakePinOut(odOut[0]),
		.haltWakePinOe(odOe[0]), .stopWakePinIn(odIn[1]),
		.stopWakePinOut(odOut[1]), .stopWakePinOe(odOe[1]),
		.openDrainPinTwoIn(odIn[2]), .openDrainPinTwoOut(odOut[2]),
		.openDrainPinTwoOe(odOe[2]), .pushPullGroupOnePinsIn(oneIn),
		.pushPullGroupOnePinsOut(oneOut), .pushPullGroupOnePinsOe(oneOe),
		.pushPullGroupTwoPinsIn(twoIn), .pushPullGroupTwoPinsOut(twoOut),
		.pushPullGroupTwoPinsOe(twoOe), .haltRelease(haltRel),
		.stopRelease(stopRel)
	);

	pin_partner pin_partner_inst (
		.odOe(odOe), .odOut(odOut), .extLow(extLow), .oneOe(oneOe),
		.oneOut(oneOut), .oneExt(oneExt), .twoOe(twoOe), .twoOut(twoOut),
		.twoExt(twoExt), .odLevel(odIn), .oneLevel(oneIn),
		.twoLevel(twoIn)
	);

	// free-running clock
	always #2 clk = ~clk;

	// one compare, counted
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	// verdict and end of run
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run

	// one write cycle, outputs settled on return
	task automatic wr(input logic [6:0] a, input logic [3:0] v);
		@(posedge clk);
		memAddr   <= a;
		memWrData <= v;
		memWrEn   <= 1'b1;
		@(posedge clk);
		memWrEn <= 1'b0;
		#1;
	endtask : wr

	// one read cycle, expected value queued for the monitor
	task automatic rd(input logic [6:0] a, input logic [3:0] e);
		expQ.push_back(e);
		@(posedge clk);
		memAddr <= a;
		memRdEn <= 1'b1;
		@(posedge clk);
		memRdEn <= 1'b0;
	endtask : rd

	// monitor: read data lands one edge after the strobe
	always @(posedge clk) begin
		rdSeen <= memRdEn;
	end
	always @(negedge clk) begin
		if (rdSeen) begin
			check({4'h0, memRdData}, {4'h0, expQ.pop_front()});
		end
	end

	// let pin filters settle
	task automatic settle();
		repeat (8) @(posedge clk);
		#1;
	endtask : settle

	// reset held for ten cycles
	task automatic do_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		settle();
	endtask : do_reset

	// watchdog against a hang
	initial begin
		#(5000 * 4);
		n_errors++;
		complete_run();
	end

	// main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		memAddr = 7'h00;
		memWrEn = 1'b0;
		memWrData = 4'h0;
		memRdEn = 1'b0;
		n_errors = 0;
		total_checks = 0;
		void'($urandom(32'h5633));
		extLow = 3'h2;
		oneExt = 4'($urandom);
		twoExt = 4'($urandom);
		do_reset();
		check({oneOe, twoOe}, 8'h00);
		check({5'h00, odOe}, 8'h00);
		check({6'h00, haltRel, stopRel}, 8'h02);
		rd(7'h71, 4'h5);
		rd(7'h72, oneExt);
		rd(7'h73, twoExt);
		rd(7'h70, 4'h0);
		// full-nibble writes, random data, both push-pull ports
		for (int i = 0; i < 4; i++) begin
			d = 4'($urandom);
			wr(7'h72, d);
			check({oneOe, oneOut}, {4'hF, d});
			wr(7'h73, ~d);
			check({twoOe, twoOut}, {4'hF, ~d});
		end
		wr(7'h74, d);
		@(posedge clk);
		oneExt <= ~d;
		extLow <= 3'h0;
		settle();
		check({oneOe, twoOut}, {4'hF, ~d});
		rd(7'h72, d);
		// open-drain port: ones float, bit three dropped
		wr(7'h71, 4'hA);
		check({5'h00, odOe}, 8'h05);
		check({5'h00, odOut}, 8'h00);
		settle();
		rd(7'h71, 4'h2);
		check({6'h00, haltRel, stopRel}, 8'h01);
		// outside pulls pin zero while all float; read shows pins
		@(posedge clk);
		extLow <= 3'h1;
		wr(7'h71, 4'hF);
		settle();
		rd(7'h71, 4'h6);
		wr(7'h71, 4'h6 & 4'hB);
		@(posedge clk);
		extLow <= 3'h0;
		settle();
		check({5'h00, odOe}, 8'h05);
		check({6'h00, haltRel, stopRel}, 8'h01);
		wr(7'h72, 4'h0);
		check({oneOe, oneOut}, 8'hF0);
		// second reset returns every port to input mode
		do_reset();
		check({oneOe, twoOe}, 8'h00);
		check({5'h00, odOe}, 8'h00);
		repeat (4) @(posedge clk);
		complete_run();
	end
endmodule : tb_top
